// File: pkg/swc_cfg.svh
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH
// Register indices, not byte addresses: byte address = 4 * index
`define SWC_IDX_CLKEN 16'hFF16
`define SWC_IDX_DIRCTL 16'hFF48
`define SWC_IDX_KMASK 16'hFF49
`define SWC_IDX_CTLST 16'hFF4A
`define SWC_IDX_CAP_MS 16'hFF4B
`define SWC_IDX_CAP_HS 16'hFF4C
`define SWC_IDX_CAP_TS 16'hFF4D
`define SWC_IDX_IRQEN 16'hFFED
`define SWC_IDX_IRQFL 16'hFFFD
`define SWC_ADDR_W 18
`define SWC_BIT_CLKEN 1
`define SWC_BIT_DIREN 0
`define SWC_BIT_SWAP 1
`define SWC_BIT_CLEAR 0
`define SWC_BIT_RUN 1
`define SWC_BIT_RENEW 2
`define SWC_BIT_CARRY 3
`define SWC_IRQ_RUN 3
`define SWC_IRQ_LAP 2
`define SWC_IRQ_1HZ 1
`define SWC_IRQ_10HZ 0
`define SWC_RST_NIB 4'h0
`define SWC_CLK_HZ 10000000
`define SWC_KEY_HZ 1024
`define SWC_MS_HZ 1000
// Cycles of one 1,024 Hz period and of one counting tick (1 ms), rounded down
`define SWC_KEY_DIV (`SWC_CLK_HZ / `SWC_KEY_HZ)
`define SWC_MS_DIV (`SWC_CLK_HZ / `SWC_MS_HZ)
`define SWC_AXI_OKAY 2'h0
`define SWC_AXI_SLVERR 2'h2
`endif

// File: pkg/swc_pkg.sv
package swc_pkg;
  typedef logic [3:0] swc_nib_t;
  typedef enum logic [1:0] {SWC_ST_FREE, SWC_ST_HELD, SWC_ST_RENEWED} swc_hold_e;
endpackage

// File: verilog/swc_bcd_digit.sv
`timescale 1ns/10ps
module swc_bcd_digit
  import swc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic step_in,
  output swc_nib_t digit_out,
  output logic wrap_out
);
  swc_nib_t digit_ff;
  swc_nib_t nxt_digit;

  assign wrap_out = step_in && (digit_ff == 4'h9);
  assign digit_out = digit_ff;

  always_comb begin
    nxt_digit = digit_ff;
    if (clear_in) begin
      nxt_digit = 4'h0;
    end else if (step_in) begin
      nxt_digit = (digit_ff == 4'h9) ? 4'h0 : digit_ff + 4'h1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      digit_ff <= 4'h0;
    end else begin
      digit_ff <= nxt_digit;
    end
  end
endmodule

// File: verilog/swc_stopwatch.sv
`timescale 1ns/10ps
`include "swc_cfg.svh"
// Operation
// - Stopwatch clock runs only while clock-enable bit is 1; resets 0.
// - Direct enable 1 gives keys run/lap control; 0 means software only.
// - Direct enable change applies at next falling 1,024 Hz edge.
// - Swap 1: port zero lap, port one run; 0 the reverse.
// - 3-bit mask code picks concurrence keys; 0 none; resets 0.
// - Concurrent mask key blocks run and lap until released.
// - Writing clear zeroes counter; running continues; reads 0.
// - Clear leaves capture buffer unchanged.
// - Run bit 1 counts, 0 stops and keeps the count.
// - Run writes work only with direct disabled; reads show real state.
// - Lap over unread held data sets renewal flag at tenths read.
// - Renewal flag updates on every tenths digit read.
// - Entering hold loads carry flag with 1 Hz flag value.
// - Reading millisecond digit starts hold; returns thousandths BCD.
// - Tenths capture digit is read-only BCD, resets 0.
// - Four interrupt enables: run, lap, 1 Hz, 10 Hz; reset 0.
// - Four flags set by events, cleared by writing 1.
// - 10 Hz and 1 Hz flags set on hundredths and tenths wraps.
// - Run and lap flags set by keys sampled at falling 1,024 Hz.
// - Keys sampled at one falling edge count as simultaneous.
module swc_stopwatch
  import swc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [`SWC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SWC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic key_port_zero_in,
  input wire logic key_port_one_in,
  input wire logic [1:0] mask_group_a_in,
  input wire logic [3:0] mask_group_b_in,
  output logic irq_out
);
  typedef struct packed {
    logic [1:0] aw_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [`SWC_ADDR_W-1:0] awaddr;
    logic w_got;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic clk_en;
    logic dir_req;
    logic dir_act;
    logic swap;
    logic [2:0] kmask;
    logic run;
    logic renew;
    logic carry;
    logic [3:0] irq_en;
    logic [3:0] irq_fl;
    logic [13:0] kdiv;
    logic [13:0] msdiv;
    logic [7:0] keys_prev;
    logic mask_block;
    swc_hold_e hold;
    logic [11:0] cap;
  } swc_state_s;

  swc_state_s st_ff;
  swc_state_s nxt_st;
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [11:0] live;
  logic [2:0] wrap;
  logic [2:0] step;
  logic tick;
  logic clear_pulse;
  logic key_edge;
  logic [7:0] keys;
  logic [7:0] pressed;
  logic [5:0] mask_sel;
  logic run_key;
  logic lap_key;
  logic run_new;
  logic lap_new;
  logic aw_fire;
  logic w_fire;
  logic do_write;
  logic ar_fire;
  logic [15:0] widx;
  logic [15:0] ridx;
  logic wr_hit;
  logic rd_hit;
  logic [3:0] wnib;
  logic [3:0] rnib;

  // Pins are asynchronous to mclk: two stages before use
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= {mask_group_b_in, mask_group_a_in, key_port_one_in, key_port_zero_in};
      sync2_ff <= sync1_ff;
    end
  end

  // Counter chain: ms, hundredths, tenths
  assign tick = st_ff.clk_en && st_ff.run && (st_ff.msdiv == 14'(`SWC_MS_DIV - 1));
  assign clear_pulse = do_write && (widx == `SWC_IDX_CTLST) && wnib[`SWC_BIT_CLEAR];
  // Step vector avoids an out-of-range wrap select on the first digit
  assign step = {wrap[1:0], tick};
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_dig
    swc_bcd_digit u_dig (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .clear_in(clear_pulse),
      .step_in(step[gi]),
      .digit_out(live[gi*4 +: 4]),
      .wrap_out(wrap[gi])
    );
  end

  // Falling edge of the 1,024 Hz clock: end of its divider period
  assign key_edge = st_ff.clk_en && (st_ff.kdiv == 14'(`SWC_KEY_DIV - 1));
  assign keys = sync2_ff;
  assign pressed = keys & ~st_ff.keys_prev;
  assign run_key = st_ff.swap ? keys[1] : keys[0];
  assign lap_key = st_ff.swap ? keys[0] : keys[1];
  always_comb begin
    case (st_ff.kmask)
      3'h1: mask_sel = 6'b000001;
      3'h2: mask_sel = 6'b000011;
      3'h3: mask_sel = 6'b000111;
      3'h4: mask_sel = 6'b000100;
      3'h5: mask_sel = 6'b001100;
      3'h6: mask_sel = 6'b011100;
      3'h7: mask_sel = 6'b111100;
      default: mask_sel = 6'b000000;
    endcase
  end
  // Code 3 shares the first b key with group a; index map a0,a1,b0..b3
  logic [5:0] mask_keys;
  logic mask_held;
  logic mask_new;
  logic rl_new;
  assign mask_keys = keys[7:2];
  assign mask_held = |(mask_keys & mask_sel & ~pressed[7:2]);
  assign mask_new = |(mask_keys & mask_sel & pressed[7:2]);
  assign rl_new = (run_key && !(st_ff.swap ? st_ff.keys_prev[1] : st_ff.keys_prev[0]))
      || (lap_key && !(st_ff.swap ? st_ff.keys_prev[0] : st_ff.keys_prev[1]));
  // A run/lap press together with a fresh mask press counts as simultaneous, so valid
  // Keys reach neither flags nor control while direct input is off
  assign run_new = st_ff.dir_act && key_edge && run_key && !(st_ff.swap ? st_ff.keys_prev[1]
      : st_ff.keys_prev[0]) && !mask_held && !st_ff.mask_block;
  assign lap_new = st_ff.dir_act && key_edge && lap_key && !(st_ff.swap ? st_ff.keys_prev[0]
      : st_ff.keys_prev[1]) && !mask_held && !st_ff.mask_block;

  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign do_write = st_ff.aw_got[0] && st_ff.w_got && !st_ff.bvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign widx = 16'(st_ff.awaddr >> 2);
  assign ridx = 16'(s_axi_araddr >> 2);
  assign wnib = st_ff.wstrb[0] ? st_ff.wdata[3:0] : st_ff.irq_fl & 4'h0;
  assign s_axi_awready = !st_ff.aw_got[0] && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign irq_out = |(st_ff.irq_fl & st_ff.irq_en);

  always_comb begin
    wr_hit = 1'b1;
    case (widx)
      `SWC_IDX_CLKEN, `SWC_IDX_DIRCTL, `SWC_IDX_KMASK, `SWC_IDX_CTLST, `SWC_IDX_CAP_MS,
      `SWC_IDX_CAP_HS, `SWC_IDX_CAP_TS, `SWC_IDX_IRQEN, `SWC_IDX_IRQFL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    rd_hit = 1'b1;
    case (ridx)
      `SWC_IDX_CLKEN: rnib = {2'b00, st_ff.clk_en, 1'b0};
      `SWC_IDX_DIRCTL: rnib = {2'b00, st_ff.swap, st_ff.dir_req};
      `SWC_IDX_KMASK: rnib = {1'b0, st_ff.kmask};
      `SWC_IDX_CTLST: rnib = {st_ff.carry, st_ff.renew, st_ff.run, 1'b0};
      `SWC_IDX_CAP_MS: rnib = (st_ff.hold == SWC_ST_FREE) ? live[3:0] : st_ff.cap[3:0];
      `SWC_IDX_CAP_HS: rnib = st_ff.cap[7:4];
      `SWC_IDX_CAP_TS: rnib = st_ff.cap[11:8];
      `SWC_IDX_IRQEN: rnib = st_ff.irq_en;
      `SWC_IDX_IRQFL: rnib = st_ff.irq_fl;
      default: begin
        rnib = 4'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    // Write channel: address and data in either order
    if (aw_fire) begin
      nxt_st.aw_got = 2'b01;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (w_fire) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // Dividers idle while clock gated to mimic the stopped supply
    if (st_ff.clk_en) begin
      nxt_st.kdiv = key_edge ? 14'h0000 : st_ff.kdiv + 14'h0001;
      if (st_ff.run) begin
        nxt_st.msdiv = tick ? 14'h0000 : st_ff.msdiv + 14'h0001;
      end
    end
    if (clear_pulse) begin
      nxt_st.msdiv = 14'h0000;
    end

    if (key_edge) begin
      nxt_st.keys_prev = keys;
      nxt_st.dir_act = st_ff.dir_req;
      // Mask stays in force until every mask key is released
      if (mask_new && !rl_new) begin
        nxt_st.mask_block = 1'b1;
      end else if (!(|(mask_keys & mask_sel))) begin
        nxt_st.mask_block = 1'b0;
      end
    end

    // Key actions only while direct input is active
    if (st_ff.dir_act) begin
      if (run_new) begin
        nxt_st.run = !st_ff.run;
      end
      if (lap_new) begin
        if (st_ff.hold == SWC_ST_FREE) begin
          nxt_st.hold = SWC_ST_HELD;
          nxt_st.cap = live;
          nxt_st.carry = st_ff.irq_fl[`SWC_IRQ_1HZ];
        end else begin
          nxt_st.hold = SWC_ST_RENEWED;
          nxt_st.cap = live;
        end
      end
    end

    // Flags: events win over a same-cycle clear
    if (do_write && widx == `SWC_IDX_IRQFL) begin
      nxt_st.irq_fl = st_ff.irq_fl & ~wnib;
    end
    if (wrap[1]) nxt_st.irq_fl[`SWC_IRQ_10HZ] = 1'b1;
    if (wrap[2]) nxt_st.irq_fl[`SWC_IRQ_1HZ] = 1'b1;
    if (run_new) nxt_st.irq_fl[`SWC_IRQ_RUN] = 1'b1;
    if (lap_new) nxt_st.irq_fl[`SWC_IRQ_LAP] = 1'b1;

    if (do_write) begin
      nxt_st.aw_got = 2'b00;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wr_hit ? `SWC_AXI_OKAY : `SWC_AXI_SLVERR;
      if (st_ff.wstrb[0]) begin
        case (widx)
          `SWC_IDX_CLKEN: nxt_st.clk_en = wnib[`SWC_BIT_CLKEN];
          `SWC_IDX_DIRCTL: begin
            nxt_st.dir_req = wnib[`SWC_BIT_DIREN];
            nxt_st.swap = wnib[`SWC_BIT_SWAP];
          end
          `SWC_IDX_KMASK: nxt_st.kmask = wnib[2:0];
          `SWC_IDX_CTLST: begin
            if (!st_ff.dir_act) begin
              nxt_st.run = wnib[`SWC_BIT_RUN];
            end
          end
          `SWC_IDX_IRQEN: nxt_st.irq_en = wnib;
          default: nxt_st.bresp = nxt_st.bresp;
        endcase
      end
    end

    if (ar_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = {28'h0000000, rnib};
      nxt_st.rresp = rd_hit ? `SWC_AXI_OKAY : `SWC_AXI_SLVERR;
      // Millisecond read freezes the buffer; a free buffer captures now
      if (ridx == `SWC_IDX_CAP_MS && st_ff.hold == SWC_ST_FREE) begin
        nxt_st.hold = SWC_ST_HELD;
        nxt_st.cap = live;
        nxt_st.carry = st_ff.irq_fl[`SWC_IRQ_1HZ];
      end
      if (ridx == `SWC_IDX_CAP_TS) begin
        // Renewed data stays held so the fresh lap can be read next
        nxt_st.renew = (st_ff.hold == SWC_ST_RENEWED);
        nxt_st.hold = (st_ff.hold == SWC_ST_RENEWED) ? SWC_ST_HELD : SWC_ST_FREE;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  a_irq_level: assert property (@(posedge mclk_in) disable iff (rst_in)
    irq_out == |(st_ff.irq_fl & st_ff.irq_en)) else $error("irq mismatch");
  a_clk_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
    !st_ff.clk_en && !clear_pulse |=> $stable(live)) else $error("counting without clock");
  a_dir_sync: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st_ff.dir_act != st_ff.dir_req) && !key_edge |=> $stable(st_ff.dir_act))
    else $error("direct enable moved off edge");
  a_run_lock: assert property (@(posedge mclk_in) disable iff (rst_in)
    do_write && widx == `SWC_IDX_CTLST && st_ff.dir_act && !run_new |=> $stable(st_ff.run))
    else $error("run written in direct mode");
  a_clear_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    clear_pulse |=> live == 12'h000) else $error("clear failed");
  a_clear_keep: assert property (@(posedge mclk_in) disable iff (rst_in)
    clear_pulse && !ar_fire && !lap_new |=> $stable(st_ff.cap)) else $error("cap hit");
  a_ten_hz_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    wrap[1] |=> st_ff.irq_fl[`SWC_IRQ_10HZ]) else $error("10 Hz flag lost");
  a_one_hz_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    wrap[2] |=> st_ff.irq_fl[`SWC_IRQ_1HZ]) else $error("1 Hz flag lost");
  a_hold_entry: assert property (@(posedge mclk_in) disable iff (rst_in)
    ar_fire && ridx == `SWC_IDX_CAP_MS && st_ff.hold == SWC_ST_FREE
    |=> st_ff.hold == SWC_ST_HELD && st_ff.carry == $past(st_ff.irq_fl[`SWC_IRQ_1HZ]))
    else $error("hold entry wrong");
  a_mask_block: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_ff.mask_block |-> !run_new && !lap_new) else $error("masked key taken");
endmodule

// File: tb/swc_keys.sv
`timescale 1ns/10ps
module swc_keys (
  input wire logic mclk_in,
  output logic key_zero_out,
  output logic key_one_out,
  output logic [1:0] grp_a_out,
  output logic [3:0] grp_b_out
);
  // Clean switches, idle released at 0; no bounce, so one press is one sampled edge
  initial begin
    key_zero_out = 1'b0;
    key_one_out = 1'b0;
    grp_a_out = 2'h0;
    grp_b_out = 4'h0;
  end
  // Span must exceed one sampling period, or a press can fall between samples
  task automatic press(input int port, input int span);
    @(posedge mclk_in);
    key_zero_out <= (port == 0);
    key_one_out <= (port == 1);
    repeat (span) @(posedge mclk_in);
    key_zero_out <= 1'b0;
    key_one_out <= 1'b0;
    repeat (span) @(posedge mclk_in);
  endtask
  task automatic hold(input logic [1:0] a, input logic [3:0] b);
    @(posedge mclk_in);
    grp_a_out <= a;
    grp_b_out <= b;
  endtask
endmodule

// File: tb/stopwatch_control_and_capture_tb.sv
`timescale 1ns/10ps
`include "swc_cfg.svh"
module stopwatch_control_and_capture_tb;
  localparam int h = `SWC_KEY_DIV + `SWC_KEY_DIV / 16;
  localparam logic [15:0] i_ct = `SWC_IDX_CTLST;
  localparam logic [15:0] i_fl = `SWC_IDX_IRQFL;
  localparam logic [15:0] i_en = `SWC_IDX_IRQEN;
  localparam logic [15:0] i_dc = `SWC_IDX_DIRCTL;
  localparam logic [15:0] i_km = `SWC_IDX_KMASK;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, k0, k1;
  logic [1:0] bresp, rresp, rs, ga;
  logic [3:0] gb;
  logic [31:0] rdata, rd;
  int n_errors = 0;
  int total_checks = 0;
  int m[int];
  int r;
  int regs[$] = '{`SWC_IDX_CLKEN, `SWC_IDX_DIRCTL, `SWC_IDX_KMASK, `SWC_IDX_CTLST,
    `SWC_IDX_CAP_MS, `SWC_IDX_CAP_HS, `SWC_IDX_CAP_TS, `SWC_IDX_IRQEN, `SWC_IDX_IRQFL};
  always #50 mclk_in = ~mclk_in;
  swc_stopwatch swc_stopwatch_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .key_port_zero_in(k0), .key_port_one_in(k1), .mask_group_a_in(ga),
    .mask_group_b_in(gb), .irq_out(irq));
  swc_keys swc_keys_i (.mclk_in(mclk_in), .key_zero_out(k0), .key_one_out(k1),
    .grp_a_out(ga), .grp_b_out(gb));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [1:0] er(input logic [15:0] idx);
    return m.exists(idx) ? `SWC_AXI_OKAY : `SWC_AXI_SLVERR;
  endfunction
  task automatic axw(input logic [15:0] idx, input logic [31:0] d);
    @(posedge mclk_in);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    chk("bresp", rs, er(idx));
  endtask
  task automatic rdc(input logic [15:0] idx, input string nm);
    @(posedge mclk_in);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    chk("rresp", rs, er(idx));
    if (m.exists(idx)) chk(nm, rd, m[idx]);
  endtask
  task automatic irqc;
    chk("irq", irq, (m[i_en] & m[i_fl]) != 0);
  endtask
  initial begin
    void'($urandom(45613));
    foreach (regs[i]) m[regs[i]] = 0;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    foreach (regs[i]) rdc(regs[i], "reset value");
    irqc();
    rdc(16'hFF4E, "unmapped");
    axw(16'hFF4E, 32'hF);
    r = $urandom_range(15);
    axw(i_en, r);
    m[i_en] = r;
    rdc(i_en, "irq enable");
    axw(i_fl, 32'hF);
    rdc(i_fl, "irq flags");
    axw(i_km, 32'hF);
    m[i_km] = 7;
    rdc(i_km, "mask select");
    axw(`SWC_IDX_CLKEN, 32'hF);
    m[`SWC_IDX_CLKEN] = 2;
    rdc(`SWC_IDX_CLKEN, "clock enable");
    axw(i_ct, 32'h1);
    rdc(i_ct, "control");
    axw(i_km, 32'h0);
    m[i_km] = 0;
    axw(i_en, 32'hC);
    m[i_en] = 12;
    axw(i_dc, 32'h1);
    m[i_dc] = 1;
    rdc(i_dc, "direct control");
    // Switch-over lands at the next slow sampling edge, so wait one period
    repeat (h) @(posedge mclk_in);
    swc_keys_i.press(0, h);
    m[i_ct] = 2;
    m[i_fl] = 8;
    rdc(i_ct, "run state");
    rdc(i_fl, "irq flags");
    irqc();
    axw(i_en, 32'h4);
    m[i_en] = 4;
    irqc();
    axw(i_fl, 32'h8);
    m[i_fl] = 0;
    rdc(i_fl, "irq flags");
    axw(i_en, 32'hC);
    m[i_en] = 12;
    axw(i_ct, 32'h0);
    rdc(i_ct, "run ignored");
    axw(i_dc, 32'h3);
    m[i_dc] = 3;
    // Clear while running: the lap lands before the first new tick, so capture is zero
    axw(i_ct, 32'h1);
    swc_keys_i.press(0, h);
    m[i_fl] = 4;
    rdc(i_fl, "lap flag");
    rdc(i_ct, "carry");
    irqc();
    rdc(`SWC_IDX_CAP_MS, "ms");
    chk("ms bcd", rd <= 9, 1);
    rdc(`SWC_IDX_CAP_HS, "hundredths");
    rdc(`SWC_IDX_CAP_TS, "tenths");
    rdc(i_ct, "renewal");
    axw(i_km, 32'h1);
    m[i_km] = 1;
    swc_keys_i.hold(2'h1, 4'h0);
    repeat (h) @(posedge mclk_in);
    swc_keys_i.press(1, h);
    rdc(i_fl, "masked flags");
    rdc(i_ct, "masked run");
    swc_keys_i.hold(2'h0, 4'h0);
    axw(i_dc, 32'h0);
    m[i_dc] = 0;
    repeat (h) @(posedge mclk_in);
    axw(i_ct, 32'h0);
    m[i_ct] = 0;
    rdc(i_ct, "stopped");
    axw(i_ct, 32'h1);
    m[`SWC_IDX_CAP_MS] = 0;
    rdc(`SWC_IDX_CAP_MS, "cleared ms");
    axw(i_ct, 32'h2);
    m[i_ct] = 2;
    rdc(i_ct, "restarted");
    test_done();
  end
  initial begin
    repeat (98000) @(posedge mclk_in);
    n_errors++;
    test_done();
  end
endmodule
